/* File: rtl/servo_seq_defines.svh */
// register map, field layout, codes and reset values of the sequence decoder
`ifndef SERVO_SEQ_DEFINES_SVH
`define SERVO_SEQ_DEFINES_SVH
`define ADR_INSEL_LAST 5'h09
`define ADR_MODE_CFG 5'h0a
`define ADR_GAIN_CFG 5'h0b
`define ADR_LOCK_LVL 5'h0c
`define ADR_STATUS 5'h0d
`define ADR_GEAR_NUM 5'h0e
`define ADR_GEAR_LAST 5'h11
`define ADR_GEAR_DEN 5'h12
`define ADR_PRESET 5'h13
`define ADR_PRESET_LAST 5'h1a
`define F_CLEAR_EDGE 0
`define F_CTRL 1
`define F_DAMP 4
`define F_INH_DIS 6
`define F_SPD 7
`define F_ZERO 9
`define MODE_CFG_RST 32'h0000_0040
`define GAIN_CFG_RST 32'h0000_0000
`define LOCK_LVL_RST 16'h0000
`define GEAR_NUM_RST 32'h0000_0001
`define GEAR_DEN_RST 32'h0000_0001
`define PRESET_RST 16'h0000
`define FN_CLEAR 4'h1
`define FN_MODE 4'h2
`define FN_GAIN 4'h3
`define FN_FLT_LO 4'h4
`define FN_FLT_HI 4'h5
`define FN_GEAR_LO 4'h6
`define FN_GEAR_HI 4'h7
`define FN_INHIBIT 4'h8
`define FN_SPD_B0 4'h9
`define FN_SPD_B1 4'ha
`define FN_SPD_B2 4'hb
`define FN_ZERO 4'hc
`define TERM_CLEAR 4'h6
`define TERM_INHIBIT 4'h9
`define INSEL_RST {5'h08, 5'h00, 5'h00, 5'h01, 5'h00, 5'h00, 5'h06, 5'h04, 5'h03, 5'h02}
`define GAIN_BY_INPUT 4'h2
`define CM_SPD 3'h1
`define CM_TRQ 3'h2
`define CM_SW_PS 3'h3
`define CM_SW_PT 3'h4
`define CM_SW_ST 3'h5
`define DAMP_PAIRS 2'h1
`define DAMP_BIN 2'h2
`define FLT_ODD 4'h5
`define FLT_EVEN 4'ha
`define FLT_ONE 4'h1
`define SPD_OFF 2'h0
`define SPD_4 2'h1
`define SPD_3A 2'h2
`define SPD_8 2'h3
`define ZERO_CMD 2'h1
`define ZERO_LOCK_MOT 2'h2
`define ZERO_LOCK_CMD 2'h3
`define CLR_EDGE_MIN_US 100
`define CLR_LEVEL_MIN_US 1000
`endif

/* File: rtl/servo_seq_pkg.sv */
// types shared by the sequence input decoder
package servo_seq_pkg;
  typedef enum logic [2:0] {
    MODE_POS = 3'b001,
    MODE_SPD = 3'b010,
    MODE_TRQ = 3'b100
  } ctrl_mode_t;
  typedef logic [9:0][4:0] insel_t;
endpackage

/* File: rtl/servo_sequence_input_decoder.sv */
// sequence input decoder with avalon-mm configuration registers
`timescale 1ns/1ps
`include "servo_seq_defines.svh"

// Summary of operation
// R1: counter clear only on terminal seven
// R2: counter clear polarity always normally open
// R3: clear zeroes error counter, stops position loop
// R4: clear acts on level or rising edge
// R5: host holds clear long enough per mode
// R6: mode switch picks first/second mode pair
// R7: gain input picks gain set when mode 2
// R8: filter inputs select damping filters per mode
// R9: gear inputs binary-select four numerators
// R10: one common gear denominator for all numerators
// R11: pulse inhibit honoured only when enable zero
// R12: pulse inhibit only on terminal ten
// R13: inhibited command pulses are not counted
// R14: speed presets disabled at select zero
// R15: speed mode 1 two bits, four presets
// R16: speed mode 2 both on means analog
// R17: speed mode 3 three bits, eight presets
// R18: zero speed input normally closed, off zeroes
// R19: unused zero input runs first preset; here it just never zeroes, speed follows the select inputs
// R20: zero speed mode sets zeroing and locking
// R21: per-terminal function and polarity selection
// R22: inputs synchronised and debounced before decoding
module servo_sequence_input_decoder #(
  parameter int NUM_TERM = 10,
  parameter int DEBOUNCE_CYCLES = 16,
  parameter int ERR_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_TERM-1:0] seq_in,
  input wire logic cmd_pulse_in,
  input wire logic fb_pulse,
  input wire logic [15:0] analog_speed_in,
  input wire logic [15:0] motor_speed_in,
  output logic [2:0] active_mode,
  output logic gain_set_two,
  output logic [3:0] filter_enable,
  output logic [31:0] gear_numerator,
  output logic [31:0] gear_denominator,
  output logic pulse_inhibited,
  output logic [ERR_W-1:0] error_count,
  output logic error_clear,
  output logic position_loop_active,
  output logic [15:0] speed_command,
  output logic analog_speed_select,
  output logic zero_speed_force,
  output logic position_lock,
  output logic clear_alloc_error,
  output logic inhibit_alloc_error
);
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic fn_level(input servo_seq_pkg::insel_t sel,
                                    input logic [9:0] lvl,
                                    input logic [3:0] code);
    fn_level = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (sel[i][3:0] == code) begin
        fn_level = fn_level | (lvl[i] ^ sel[i][4]);
      end
    end
  endfunction

  function automatic logic fn_used(input servo_seq_pkg::insel_t sel,
                                   input logic [3:0] code);
    fn_used = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (sel[i][3:0] == code) begin
        fn_used = 1'b1;
      end
    end
  endfunction

  function automatic logic misplaced(input servo_seq_pkg::insel_t sel,
                                     input logic [3:0] code,
                                     input logic [3:0] term);
    misplaced = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (i[3:0] != term && sel[i][3:0] == code) begin
        misplaced = 1'b1;
      end
    end
  endfunction

  function automatic logic [15:0] mag16(input logic [15:0] v);
    mag16 = v[15] ? (~v + 16'h0001) : v;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  servo_seq_pkg::insel_t insel_q;
  logic [31:0] cfg_q;
  logic [31:0] gain_q;
  logic [15:0] lock_lvl_q;
  logic [31:0] gear_num_q [4];
  logic [31:0] gear_den_q;
  logic [15:0] preset_q [8];
  logic wait_q;
  logic [31:0] rdata_q;
  logic [NUM_TERM-1:0] stable_w;

  // ----------------------------------------------------------------
  // input synchronisers and debounce
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_term
      logic s1_q;
      logic s2_q;
      logic st_q;
      logic [CW-1:0] cnt_q;
      // a level must stay put for the whole count to be taken
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          st_q <= 1'b0;
          cnt_q <= '0;
        end else begin
          s1_q <= seq_in[g]; // R22
          s2_q <= s1_q;
          if (s2_q == st_q) begin
            cnt_q <= '0;
          end else if (cnt_q == CW'(DEBOUNCE_CYCLES - 1)) begin
            st_q <= s2_q; // R22
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
      end
      assign stable_w[g] = st_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  wire req_w = avs_read | avs_write;
  wire wr_w = avs_write & ~wait_q;
  wire [4:0] gear_off_w = avs_address - `ADR_GEAR_NUM;
  wire [4:0] pre_off_w = avs_address - `ADR_PRESET;
  wire is_insel_w = avs_address <= `ADR_INSEL_LAST;
  wire is_gear_w = avs_address >= `ADR_GEAR_NUM && avs_address <= `ADR_GEAR_LAST;
  wire is_pre_w = avs_address >= `ADR_PRESET && avs_address <= `ADR_PRESET_LAST;
  wire [31:0] status_w;
  wire [31:0] rd_w =
    is_insel_w ? {27'h0, insel_q[avs_address[3:0]]} :
    (avs_address == `ADR_MODE_CFG) ? {21'h0, cfg_q[10:0]} :
    (avs_address == `ADR_GAIN_CFG) ? {20'h0, gain_q[11:0]} :
    (avs_address == `ADR_LOCK_LVL) ? {16'h0, lock_lvl_q} :
    (avs_address == `ADR_STATUS) ? status_w :
    is_gear_w ? gear_num_q[gear_off_w[1:0]] :
    (avs_address == `ADR_GEAR_DEN) ? gear_den_q :
    is_pre_w ? {16'h0, preset_q[pre_off_w[2:0]]} : 32'h0;

  // one wait state: data is latched on the first edge, handed over on the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= ~(req_w & wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= rd_w;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      insel_q <= `INSEL_RST;
      cfg_q <= `MODE_CFG_RST;
      gain_q <= `GAIN_CFG_RST;
      lock_lvl_q <= `LOCK_LVL_RST;
      gear_den_q <= `GEAR_DEN_RST;
      for (int i = 0; i < 4; i++) begin
        gear_num_q[i] <= `GEAR_NUM_RST;
      end
      for (int i = 0; i < 8; i++) begin
        preset_q[i] <= `PRESET_RST;
      end
    end else if (wr_w) begin
      if (is_insel_w) begin
        insel_q[avs_address[3:0]] <= avs_writedata[4:0]; // R21
      end
      if (avs_address == `ADR_MODE_CFG) begin
        cfg_q <= {21'h0, avs_writedata[10:0]};
      end
      if (avs_address == `ADR_GAIN_CFG) begin
        gain_q <= {20'h0, avs_writedata[11:0]};
      end
      if (avs_address == `ADR_LOCK_LVL) begin
        lock_lvl_q <= avs_writedata[15:0];
      end
      if (is_gear_w) begin
        gear_num_q[gear_off_w[1:0]] <= avs_writedata;
      end
      if (avs_address == `ADR_GEAR_DEN) begin
        gear_den_q <= avs_writedata;
      end
      if (is_pre_w) begin
        preset_q[pre_off_w[2:0]] <= avs_writedata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------
  wire [9:0] lv_w = stable_w[9:0];
  wire clear_edge_w = cfg_q[`F_CLEAR_EDGE];
  wire [2:0] cm_w = cfg_q[`F_CTRL +: 3];
  wire [1:0] damp_w = cfg_q[`F_DAMP +: 2];
  wire inh_dis_w = cfg_q[`F_INH_DIS];
  wire [1:0] spd_w = cfg_q[`F_SPD +: 2];
  wire [1:0] zm_w = cfg_q[`F_ZERO +: 2];
  // polarity bit ignored: this input is always normally open
  wire cc_lvl_w = insel_q[`TERM_CLEAR][3:0] == `FN_CLEAR && lv_w[`TERM_CLEAR]; // R1 R2
  wire clr_bad_w = misplaced(insel_q, `FN_CLEAR, `TERM_CLEAR); // R1
  wire inh_bad_w = misplaced(insel_q, `FN_INHIBIT, `TERM_INHIBIT); // R12
  wire inh_lvl_w = insel_q[`TERM_INHIBIT][3:0] == `FN_INHIBIT &&
                   (lv_w[`TERM_INHIBIT] ^ insel_q[`TERM_INHIBIT][4]); // R12
  wire inhibit_w = inh_lvl_w & ~inh_dis_w; // R11
  wire mode_lvl_w = fn_level(insel_q, lv_w, `FN_MODE);
  wire gain_lvl_w = fn_level(insel_q, lv_w, `FN_GAIN);
  wire flo_w = fn_level(insel_q, lv_w, `FN_FLT_LO);
  wire fhi_w = fn_level(insel_q, lv_w, `FN_FLT_HI);
  wire [1:0] gear_idx_w = {fn_level(insel_q, lv_w, `FN_GEAR_HI),
                           fn_level(insel_q, lv_w, `FN_GEAR_LO)}; // R9
  wire [2:0] vsel_w = {fn_level(insel_q, lv_w, `FN_SPD_B2),
                       fn_level(insel_q, lv_w, `FN_SPD_B1),
                       fn_level(insel_q, lv_w, `FN_SPD_B0)};
  wire zero_used_w = fn_used(insel_q, `FN_ZERO);
  wire zero_lvl_w = fn_level(insel_q, lv_w, `FN_ZERO);

  // ----------------------------------------------------------------
  // counter clear and error counter
  // ----------------------------------------------------------------
  logic cc_prev_q;
  logic cp1_q;
  logic cp2_q;
  logic cp3_q;
  logic [ERR_W-1:0] err_q;
  logic err_clr_q;
  logic loop_q;
  wire clear_now_w = clear_edge_w ? (cc_lvl_w & ~cc_prev_q) : cc_lvl_w; // R4
  wire accept_w = cp2_q & ~cp3_q & ~inhibit_w; // R13

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cc_prev_q <= 1'b0;
      cp1_q <= 1'b0;
      cp2_q <= 1'b0;
      cp3_q <= 1'b0;
    end else begin
      cc_prev_q <= cc_lvl_w;
      cp1_q <= cmd_pulse_in;
      cp2_q <= cp1_q;
      cp3_q <= cp2_q;
    end
  end

  // clear beats any pulse arriving in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= '0;
      err_clr_q <= 1'b0;
      loop_q <= 1'b0;
    end else begin
      err_clr_q <= clear_now_w;
      if (clear_now_w) begin
        err_q <= '0; // R3
        loop_q <= 1'b0; // R3
      end else begin
        err_q <= err_q + ERR_W'(accept_w) - ERR_W'(fb_pulse); // R13
        if (accept_w) begin
          loop_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mode, gain, filter, gear and speed selection
  // ----------------------------------------------------------------
  servo_seq_pkg::ctrl_mode_t mode_w;
  assign mode_w =
    (cm_w == `CM_SPD) ? servo_seq_pkg::MODE_SPD :
    (cm_w == `CM_TRQ) ? servo_seq_pkg::MODE_TRQ :
    (cm_w == `CM_SW_PS) ? (mode_lvl_w ? servo_seq_pkg::MODE_SPD : servo_seq_pkg::MODE_POS) :
    (cm_w == `CM_SW_PT) ? (mode_lvl_w ? servo_seq_pkg::MODE_TRQ : servo_seq_pkg::MODE_POS) :
    (cm_w == `CM_SW_ST) ? (mode_lvl_w ? servo_seq_pkg::MODE_TRQ : servo_seq_pkg::MODE_SPD) :
    servo_seq_pkg::MODE_POS; // R6
  wire [3:0] gmode_w =
    (mode_w == servo_seq_pkg::MODE_POS) ? gain_q[3:0] :
    (mode_w == servo_seq_pkg::MODE_SPD) ? gain_q[7:4] : gain_q[11:8];
  wire gain2_w = gmode_w == `GAIN_BY_INPUT && gain_lvl_w; // R7
  wire [3:0] flt_w =
    (damp_w == `DAMP_PAIRS) ? (flo_w ? `FLT_EVEN : `FLT_ODD) :
    (damp_w == `DAMP_BIN) ? (`FLT_ONE << {fhi_w, flo_w}) : 4'h0; // R8
  wire [2:0] pidx_w = (spd_w == `SPD_8) ? vsel_w : {1'b0, vsel_w[1:0]}; // R15 R17
  wire analog_w = spd_w == `SPD_OFF ||
                  (spd_w == `SPD_3A && vsel_w[1:0] == 2'h3); // R14 R16
  // designation asserted on an off level; unallocated input never zeroes
  wire zero_on_w = zero_used_w & ~zero_lvl_w; // R18 R19
  wire zforce_w = zero_on_w && (zm_w == `ZERO_CMD || zm_w == `ZERO_LOCK_MOT); // R20
  wire lock_w = zero_on_w &&
    ((zm_w == `ZERO_LOCK_MOT && mag16(motor_speed_in) <= lock_lvl_q) ||
     (zm_w == `ZERO_LOCK_CMD && mag16(speed_command) <= lock_lvl_q)); // R20
  wire [15:0] spd_next_w = zforce_w ? 16'h0000 :
                           analog_w ? analog_speed_in : preset_q[pidx_w];

  logic [2:0] mode_q;
  logic gain2_q;
  logic [3:0] flt_q;
  logic [31:0] gnum_q;
  logic inh_q;
  logic [15:0] spd_q;
  logic analog_q;
  logic zforce_q;
  logic lock_q;
  logic clr_bad_q;
  logic inh_bad_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= servo_seq_pkg::MODE_POS;
      gain2_q <= 1'b0;
      flt_q <= 4'h0;
      gnum_q <= `GEAR_NUM_RST;
      inh_q <= 1'b0;
      spd_q <= 16'h0000;
      analog_q <= 1'b1;
      zforce_q <= 1'b0;
      lock_q <= 1'b0;
      clr_bad_q <= 1'b0;
      inh_bad_q <= 1'b0;
    end else begin
      mode_q <= mode_w;
      gain2_q <= gain2_w;
      flt_q <= flt_w;
      gnum_q <= gear_num_q[gear_idx_w]; // R9
      inh_q <= inhibit_w;
      spd_q <= spd_next_w;
      analog_q <= analog_w;
      zforce_q <= zforce_w;
      lock_q <= lock_w;
      clr_bad_q <= clr_bad_w;
      inh_bad_q <= inh_bad_w;
    end
  end

  assign status_w = {6'h0, lv_w, loop_q, lock_q, zforce_q, analog_q, gear_idx_w,
                     flt_q, gain2_q, mode_q, inh_bad_q, clr_bad_q};

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign active_mode = mode_q;
  assign gain_set_two = gain2_q;
  assign filter_enable = flt_q;
  assign gear_numerator = gnum_q;
  assign gear_denominator = gear_den_q; // R10
  assign pulse_inhibited = inh_q;
  assign error_count = err_q;
  assign error_clear = err_clr_q;
  assign position_loop_active = loop_q;
  assign speed_command = spd_q;
  assign analog_speed_select = analog_q;
  assign zero_speed_force = zforce_q;
  assign position_lock = lock_q;
  assign clear_alloc_error = clr_bad_q;
  assign inhibit_alloc_error = inh_bad_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_CLEAR_TERM: assert property ( // R1
    clr_bad_w |=> clear_alloc_error) else $error("misplaced clear not flagged");
  AST_CLEAR_NO_NC: assert property ( // R2
    (insel_q[`TERM_CLEAR][3:0] == `FN_CLEAR && !lv_w[`TERM_CLEAR] && !clear_edge_w)
    |=> !error_clear) else $error("clear acted on an off level");
  AST_CLEAR_ZERO: assert property ( // R3
    clear_now_w |=> (error_count == '0 && !position_loop_active))
    else $error("clear did not zero the counter");
  AST_EDGE_ONCE: assert property ( // R4
    (clear_edge_w && cc_lvl_w && cc_prev_q) |=> !error_clear)
    else $error("edge mode cleared on a held level");
  AST_MODE_SW: assert property ( // R6
    (cm_w == `CM_SW_ST && mode_lvl_w) |=> active_mode == servo_seq_pkg::MODE_TRQ)
    else $error("mode switch pair wrong");
  AST_GAIN: assert property ( // R7
    (gmode_w != `GAIN_BY_INPUT) |=> !gain_set_two) else $error("gain set two wrongly on");
  AST_FILTER: assert property ( // R8
    (damp_w == `DAMP_BIN && flo_w && fhi_w) |=> filter_enable == 4'h8)
    else $error("filter four not selected");
  AST_GEAR: assert property ( // R9
    (gear_idx_w == 2'h3) |=> gear_numerator == $past(gear_num_q[3]))
    else $error("gear numerator four not used");
  AST_INHIBIT: assert property ( // R13
    (inhibit_w && !fb_pulse && !clear_now_w) |=> $stable(error_count))
    else $error("inhibited pulse counted");
  AST_ANALOG: assert property ( // R16
    (spd_w == `SPD_3A && vsel_w[1:0] == 2'h3 && !zforce_w) |=>
    (analog_speed_select && speed_command == $past(analog_speed_in)))
    else $error("analog command not taken");
  AST_ZERO: assert property ( // R18
    zforce_w |=> speed_command == 16'h0000) else $error("speed not forced to zero");
  AST_BUS: assert property (
    (req_w && wait_q) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not in one wait state");

  COV_EDGE_CLEAR: cover property (clear_edge_w && clear_now_w ##1 error_clear);
  COV_MODE_FLIP: cover property ($changed(active_mode) && cm_w == `CM_SW_PS);
  COV_PRESET8: cover property (spd_w == `SPD_8 && pidx_w == 3'h7 && !zforce_w);
  COV_LOCK: cover property ($rose(position_lock));
endmodule // servo_sequence_input_decoder

/* File: verif/host_seq_model.sv */
// host controller model driving sequence terminals and command pulses
`timescale 1ns/1ps
`include "servo_seq_defines.svh"
module host_seq_model #(
  parameter int DEB = 2
) (
  input wire logic core_clk,
  output logic [9:0] seq_in,
  output logic cmd_pulse_in
);
  initial begin
    seq_in = 10'h000;
    cmd_pulse_in = 1'b0;
  end
  // ----------------------------------------
  // terminal levels
  // ----------------------------------------
  // a clear is held for the level-mode minimum (10 cycles a us), which covers edge mode too
  task automatic set_terms(input logic [9:0] v);
    seq_in <= v;
    repeat (DEB + 6) @(posedge core_clk);
    if (v[`TERM_CLEAR]) repeat (`CLR_LEVEL_MIN_US * 10) @(posedge core_clk);
  endtask
  // two cycles high, two low: the pin sync never misses an edge
  task automatic pulses(input int n);
    repeat (n) begin
      cmd_pulse_in <= 1'b1;
      repeat (2) @(posedge core_clk);
      cmd_pulse_in <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask
endmodule // host_seq_model

/* File: verif/test_servo_sequence_input_decoder.sv */
// self-checking bench for the sequence input decoder
`timescale 1ns/1ps
`include "servo_seq_defines.svh"
module test_servo_sequence_input_decoder;
  typedef struct {string name; logic [31:0] val;} note_t;
  note_t q[$];
  note_t nt;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int i;
  int j;
  int probe_sel;
  logic probe, an, core_clk, rst_n, avs_read, avs_write, fb_pulse, cmd_pulse_in;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, gear_numerator, gear_denominator, den;
  logic [31:0] num [4];
  logic [15:0] pre [8];
  logic [15:0] analog_speed_in, motor_speed_in, speed_command, error_count;
  logic [9:0] seq_in;
  logic [49:0] insel;
  logic [3:0] filter_enable;
  logic [2:0] active_mode;
  logic avs_waitrequest, gain_set_two, pulse_inhibited, error_clear, position_loop_active;
  logic analog_speed_select, zero_speed_force, position_lock;
  logic clear_alloc_error, inhibit_alloc_error;
  servo_seq_pkg::ctrl_mode_t m;
  logic [31:0] pv [15];
  assign pv[0] = {29'h0, active_mode};
  assign pv[1] = {31'h0, gain_set_two};
  assign pv[2] = {28'h0, filter_enable};
  assign pv[3] = gear_numerator;
  assign pv[4] = gear_denominator;
  assign pv[5] = {16'h0, speed_command};
  assign pv[6] = {31'h0, analog_speed_select};
  assign pv[7] = {31'h0, zero_speed_force};
  assign pv[8] = {31'h0, position_lock};
  assign pv[9] = {16'h0, error_count};
  assign pv[10] = {31'h0, error_clear};
  assign pv[11] = {31'h0, position_loop_active};
  assign pv[12] = {31'h0, pulse_inhibited};
  assign pv[13] = {31'h0, clear_alloc_error};
  assign pv[14] = {31'h0, inhibit_alloc_error};

  servo_sequence_input_decoder #(.DEBOUNCE_CYCLES(2)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .seq_in(seq_in), .cmd_pulse_in(cmd_pulse_in),
    .fb_pulse(fb_pulse), .analog_speed_in(analog_speed_in), .motor_speed_in(motor_speed_in),
    .active_mode(active_mode), .gain_set_two(gain_set_two), .filter_enable(filter_enable),
    .gear_numerator(gear_numerator), .gear_denominator(gear_denominator),
    .pulse_inhibited(pulse_inhibited), .error_count(error_count), .error_clear(error_clear),
    .position_loop_active(position_loop_active), .speed_command(speed_command),
    .analog_speed_select(analog_speed_select), .zero_speed_force(zero_speed_force),
    .position_lock(position_lock), .clear_alloc_error(clear_alloc_error),
    .inhibit_alloc_error(inhibit_alloc_error)
  );
  host_seq_model #(.DEB(2)) host (
    .core_clk(core_clk),
    .seq_in(seq_in),
    .cmd_pulse_in(cmd_pulse_in)
  );

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // request held until waitrequest is sampled low; one idle edge after
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string nm);
    q.push_back('{nm, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic pc(input int s, input string nm, input logic [31:0] e);
    q.push_back('{nm, e});
    probe_sel <= s;
    probe <= 1'b1;
    @(posedge core_clk);
    probe <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [31:0] cfg(input int e, cm, dm, ih, sp, z);
    cfg = 32'(e) | (32'(cm) << `F_CTRL) | (32'(dm) << `F_DAMP) | (32'(ih) << `F_INH_DIS)
      | (32'(sp) << `F_SPD) | (32'(z) << `F_ZERO);
  endfunction

  always @(posedge core_clk) begin
    if ((avs_read && avs_waitrequest === 1'b0) || probe) begin
      nt = q.pop_front();
      chk(nt.name, probe ? pv[probe_sel] : avs_readdata, nt.val);
    end
  end
  // sized for the whole sequence with wide margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 50000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, fb_pulse, probe} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    probe_sel = 0;
    motor_speed_in = 16'hc000;
    void'($urandom(33307));
    analog_speed_in = 16'($urandom);
    den = $urandom;
    for (i = 0; i < 4; i++) num[i] = $urandom;
    for (i = 0; i < 8; i++) pre[i] = 16'($urandom_range(1000, 1));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    insel = `INSEL_RST;
    for (i = 0; i < 10; i++) rd_chk(5'(i), {27'h0, insel[i*5 +: 5]}, "insel");
    rd_chk(`ADR_MODE_CFG, `MODE_CFG_RST, "mode_cfg");
    rd_chk(`ADR_GEAR_NUM, `GEAR_NUM_RST, "gear_num1");
    bus(1'b1, 5'h1f, 32'hffff_ffff);
    rd_chk(5'h1f, 32'h0, "unmapped");
    pc(13, "clr_alloc", 32'h0);
    for (i = 0; i < 4; i++) bus(1'b1, 5'(`ADR_GEAR_NUM + i), num[i]);
    bus(1'b1, `ADR_GEAR_DEN, den);
    for (i = 0; i < 8; i++) bus(1'b1, 5'(`ADR_PRESET + i), {16'h0, pre[i]});
    bus(1'b1, `ADR_LOCK_LVL, 32'h4000);
    bus(1'b1, 5'h04, {28'h0, `FN_FLT_HI});
    bus(1'b1, 5'h05, {28'h0, `FN_GEAR_HI});
    bus(1'b1, 5'h07, {28'h0, `FN_SPD_B0});
    bus(1'b1, 5'h08, {28'h0, `FN_SPD_B1});
    for (i = 3; i < 6; i++) for (j = 0; j < 2; j++) begin
      bus(1'b1, `ADR_MODE_CFG, cfg(0, i, 0, 1, 0, 0));
      host.set_terms(10'(j));
      m = (i == 5 && j == 0) ? servo_seq_pkg::MODE_SPD : (j == 0 ? servo_seq_pkg::MODE_POS :
        (i == 3 ? servo_seq_pkg::MODE_SPD : servo_seq_pkg::MODE_TRQ));
      pc(0, "active_mode", {29'h0, m});
    end
    bus(1'b1, `ADR_MODE_CFG, cfg(0, 0, 0, 1, 0, 0));
    bus(1'b1, `ADR_GAIN_CFG, 32'h2);
    for (j = 0; j < 2; j++) begin
      host.set_terms(10'(j * 2));
      pc(1, "gain", 32'(j));
    end
    bus(1'b1, `ADR_GAIN_CFG, 32'h1);
    pc(1, "gain", 32'h0);
    for (i = 1; i < 3; i++) for (j = 0; j < 4; j++) begin
      bus(1'b1, `ADR_MODE_CFG, cfg(0, 0, i, 1, 0, 0));
      host.set_terms({5'h0, j[1], 1'b0, j[0], 2'b0});
      pc(2, "filters", i == 1 ? (j[0] ? 32'ha : 32'h5) : 32'h1 << j);
    end
    for (j = 0; j < 4; j++) begin
      host.set_terms({4'h0, j[1], 1'b0, j[0], 3'h0});
      pc(3, "gear_num", num[j]);
      pc(4, "gear_den", den);
    end
    bus(1'b1, 5'h04, {28'h0, `FN_SPD_B2});
    bus(1'b1, 5'h05, 32'h0);
    for (i = 0; i < 4; i++) for (j = 0; j < 8; j++) begin
      analog_speed_in <= 16'($urandom);
      bus(1'b1, `ADR_MODE_CFG, cfg(0, 1, 0, 1, i, 0));
      host.set_terms({1'b0, j[1], j[0], 2'b0, j[2], 4'h0});
      an = (i == 0) || (i == 2 && j[1:0] == 2'h3);
      pc(5, "speed", {16'h0, an ? analog_speed_in : pre[i == 3 ? j : j % 4]});
      pc(6, "analog_sel", 32'(an));
    end
    bus(1'b1, 5'h05, {28'h0, `FN_ZERO});
    for (i = 1; i < 4; i++) for (j = 0; j < 2; j++) begin
      bus(1'b1, `ADR_MODE_CFG, cfg(0, 1, 0, 1, 1, i));
      host.set_terms(10'(j) << 5);
      pc(7, "zero_force", 32'(j == 0 && i < 3));
      pc(8, "lock", 32'(j == 0 && i > 1));
      pc(5, "speed", (j == 0 && i < 3) ? 32'h0 : {16'h0, pre[0]});
    end
    bus(1'b1, `ADR_MODE_CFG, cfg(0, 0, 0, 1, 0, 0));
    host.set_terms(10'h200);
    host.pulses(5);
    pc(12, "inhibited", 32'h0);
    pc(9, "err_cnt", 32'h5);
    pc(11, "loop", 32'h1);
    fb_pulse <= 1'b1;
    @(posedge core_clk);
    fb_pulse <= 1'b0;
    @(posedge core_clk);
    pc(9, "err_cnt", 32'h4);
    bus(1'b1, `ADR_MODE_CFG, cfg(0, 0, 0, 0, 0, 0));
    pc(12, "inhibited", 32'h1);
    host.pulses(3);
    pc(9, "err_cnt", 32'h4);
    host.set_terms(10'h240);
    pc(10, "clear", 32'h1);
    pc(9, "err_cnt", 32'h0);
    pc(11, "loop", 32'h0);
    host.set_terms(10'h000);
    bus(1'b1, `ADR_MODE_CFG, cfg(1, 0, 0, 0, 0, 0));
    host.pulses(3);
    pc(9, "err_cnt", 32'h3);
    host.set_terms(10'h040);
    pc(10, "clear", 32'h0);
    pc(9, "err_cnt", 32'h0);
    host.set_terms(10'h000);
    // inversion bit set: a low pin must still mean no clear
    bus(1'b1, 5'h06, 32'h11);
    bus(1'b1, `ADR_MODE_CFG, cfg(0, 0, 0, 1, 0, 0));
    host.pulses(2);
    pc(9, "err_cnt", 32'h2);
    bus(1'b1, 5'h00, {28'h0, `FN_CLEAR});
    pc(13, "clr_alloc", 32'h1);
    bus(1'b1, 5'h07, {28'h0, `FN_INHIBIT});
    pc(14, "inh_alloc", 32'h1);
    summarize();
  end
endmodule // test_servo_sequence_input_decoder
